//--- verilog/ocs_regs.vh
// register offsets, field positions and reset values of the output capture status unit
`ifndef OCS_REGS_VH
`define OCS_REGS_VH

`define OCS_IDX_STATUS      4'h9
`define OCS_IDX_PULSE       4'ha
`define OCS_IDX_SIGNATURE   4'hb
`define OCS_IDX_SAMPLE      4'hc
`define OCS_ADDR_STATUS     12'h024
`define OCS_ADDR_PULSE      12'h028
`define OCS_ADDR_SIGNATURE  12'h02c
`define OCS_ADDR_SAMPLE     12'h030

`define OCS_BIT_ARM         0
`define OCS_BIT_LOST        1
`define OCS_BIT_INT_EN      2
`define OCS_BIT_SPARE       3
`define OCS_BIT_OVF_PULSE   4
`define OCS_BIT_OVF_EN      5
`define OCS_BIT_OVF         6
`define OCS_BIT_STANDBY     7

`define OCS_STATUS_RESET    8'h00
`define OCS_SIG_RESET       8'h00
`define OCS_SIG_POLY        8'h1d

`endif

//--- verilog/ocs_sync2.v
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
`default_nettype none
module ocs_sync2 #(
   parameter W = 1
) (
   input  wire         pclk,     // clock
   input  wire         presetn,  // async reset, low
   input  wire [W-1:0] d,        // asynchronous input
   output reg  [W-1:0] q         // synchronised output
);
   reg [W-1:0] meta;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= {W{1'b0}};
         q    <= {W{1'b0}};
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule
`default_nettype wire

//--- verilog/ocs_signature.v
// nonlinear feedback signature generator over sync and sample bits
`include "ocs_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module ocs_signature #(
   parameter DW = 16
) (
   input  wire          pclk,        // clock
   input  wire          presetn,     // async reset, low
   input  wire          step,        // accumulate one output word
   input  wire          block_sync,  // block sync output bit
   input  wire          frame_sync,  // frame sync output bit
   input  wire [DW-1:0] i_data,      // i output word
   input  wire [DW-1:0] q_data,      // q output word
   input  wire          sync_fall,   // internal sync went low
   output reg  [7:0]    result       // stored checksum
);
   reg  [7:0] acc;
   wire [7:0] fold;
   wire [7:0] fb;
   genvar g;

   // fold the sample bits into one byte
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_fold
         assign fold[g] = ^{i_data[g % DW], q_data[(g + 8) % DW],
                            i_data[(g + 8) % DW], q_data[g % DW]};
      end
   endgenerate

   // nonlinear term: and of two taps mixed into the feedback
   assign fb = acc[7] ? `OCS_SIG_POLY : 8'h00;
   wire [7:0] mix = {acc[6:0], (acc[7] & acc[3]) ^ block_sync ^ frame_sync};

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc    <= `OCS_SIG_RESET;
         result <= `OCS_SIG_RESET;
      end else if (sync_fall) begin
         result <= acc;
         acc    <= `OCS_SIG_RESET;
      end else if (step) begin
         acc    <= mix ^ fb ^ fold;
      end
   end
endmodule
`default_nettype wire

//--- verilog/ocs_status_unit.v
// output capture status unit: apb register bank, capture, overflow, one-shot, checksum
`include "ocs_regs.vh"
`timescale 1ns/1ps
`default_nettype none

// How it works
// - software sets arm bit 0; hardware clears it after latching a sample
// - sample arriving while arm is clear sets sample-lost bit 1
// - writing 0 clears sample-lost; writing 1 leaves it
// - interrupt-enable low holds int pin high, else pin follows arm
// - pulse-select low: pin is inverted overflow flag; else one-cycle low pulse
// - reporting disabled: no flag set, pin never low; saturation detection unaffected
// - overflow sets sticky bit 6; cleared only by writing 0
// - standby bit 7 requests slow clock; registers kept, output data invalid
// - captured i and q held readable after arm falls
// - writing 01 arms and clears lost; 03 arms and keeps lost
// - sample during an arming write while arm is already set leaves arm stuck high, no capture
// - any write to pulse address fires the one-shot pin; data ignored
// - 8-bit nonlinear signature over sync and sample bits, read at 11
// - internal sync falling stores signature and clears generator
module ocs_status_unit #(
   parameter DW = 16
) (
   input  wire          pclk,               // apb clock, 100 mhz
   input  wire          presetn,            // async reset, low
   input  wire          psel,               // apb select
   input  wire          penable,            // apb access phase
   input  wire          pwrite,             // apb direction
   input  wire [11:0]   paddr,              // apb byte address
   input  wire [31:0]   pwdata,             // apb write data
   input  wire [3:0]    pstrb,              // apb byte strobes
   output wire          pready,             // apb ready
   output reg  [31:0]   prdata,             // apb read data
   output wire          pslverr,            // apb error
   input  wire          sample_valid,       // new output sample, one cycle
   input  wire [DW-1:0] sample_i,           // i output word
   input  wire [DW-1:0] sample_q,           // q output word
   input  wire          block_sync_output,  // block sync output bit
   input  wire          frame_sync_output,  // frame sync output bit
   input  wire          overflow_event,     // gain path overflow, one cycle
   input  wire          internal_sync,      // internal sync, asynchronous level
   output wire          int_n_pin,          // interrupt, low active
   output wire          ovf_n_pin,          // overflow pin, low active
   output reg           pulse_n_pin,        // one-shot pin, low active
   output wire          standby_request,    // standby to the clock unit
   output wire          output_data_valid   // output data usable
);
   // -----------------------------------------
   // bus decode
   // -----------------------------------------
   function is_addr;
      input [11:0] a;
      input [11:0] ref_a;
      begin
         is_addr = (a == ref_a);
      end
   endfunction

   wire access   = psel & penable;
   wire wr       = access & pwrite;
   wire wr_stat  = wr & is_addr(paddr, `OCS_ADDR_STATUS) & pstrb[0];
   wire wr_pulse = wr & is_addr(paddr, `OCS_ADDR_PULSE);
   wire mapped   = is_addr(paddr, `OCS_ADDR_STATUS) | is_addr(paddr, `OCS_ADDR_PULSE)
                 | is_addr(paddr, `OCS_ADDR_SIGNATURE) | is_addr(paddr, `OCS_ADDR_SAMPLE);
   wire rd_wo    = ~pwrite & is_addr(paddr, `OCS_ADDR_PULSE);
   wire wr_ro    = pwrite & (is_addr(paddr, `OCS_ADDR_SIGNATURE)
                 | is_addr(paddr, `OCS_ADDR_SAMPLE));

   assign pready  = 1'b1;
   assign pslverr = access & (~mapped | rd_wo | wr_ro);

   // -----------------------------------------
   // synchronised pin input
   // -----------------------------------------
   wire sync_s;
   reg  sync_d;
   ocs_sync2 #(.W(1)) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (internal_sync),
      .q       (sync_s)
   );
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_d <= 1'b0;
      end else begin
         sync_d <= sync_s;
      end
   end
   wire sync_fall = sync_d & ~sync_s;

   // -----------------------------------------
   // status register
   // -----------------------------------------
   reg          arm;
   reg          stuck;
   reg          lost;
   reg          int_en;
   reg          spare;
   reg          ovf_pin_pulse_select;
   reg          ovf_report_enable;
   reg          ovf;
   reg          standby;
   reg [DW-1:0] cap_i;
   reg [DW-1:0] cap_q;

   wire [7:0] wd        = pwdata[7:0];
   wire       arm_set   = wr_stat & wd[`OCS_BIT_ARM];
   // capture only when armed and not stuck; a sample landing on the arming write is not taken
   wire       capture   = sample_valid & arm & ~arm_set & ~stuck;
   // a stuck arm bit shows itself by raising the lost flag
   wire       lost_hit  = sample_valid & (~arm | stuck);
   wire       ovf_hit   = overflow_event & ovf_report_enable;

   reg next_arm;
   reg next_stuck;
   reg next_lost;
   reg next_ovf;
   always @* begin
      next_arm   = arm;
      next_stuck = stuck;
      next_lost  = lost;
      next_ovf   = ovf;
      if (wr_stat) begin
         next_arm = wd[`OCS_BIT_ARM];
         if (!wd[`OCS_BIT_LOST])
            next_lost = 1'b0;
         if (!wd[`OCS_BIT_OVF])
            next_ovf = 1'b0;
      end
      if (capture)
         next_arm = 1'b0;
      // only clearing the arm bit leaves the stuck state
      if (wr_stat & ~wd[`OCS_BIT_ARM])
         next_stuck = 1'b0;
      if (arm_set & sample_valid & arm) begin
         next_arm   = 1'b1;
         next_stuck = 1'b1;
      end
      if (lost_hit)
         next_lost = 1'b1;
      if (ovf_hit)
         next_ovf = 1'b1;
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         arm                  <= 1'b0;
         stuck                <= 1'b0;
         lost                 <= 1'b0;
         int_en               <= 1'b0;
         spare                <= 1'b0;
         ovf_pin_pulse_select <= 1'b0;
         ovf_report_enable    <= 1'b0;
         ovf                  <= 1'b0;
         standby              <= 1'b0;
      end else begin
         arm   <= next_arm;
         stuck <= next_stuck;
         lost  <= next_lost;
         ovf   <= next_ovf;
         if (wr_stat) begin
            int_en               <= wd[`OCS_BIT_INT_EN];
            spare                <= wd[`OCS_BIT_SPARE];
            ovf_pin_pulse_select <= wd[`OCS_BIT_OVF_PULSE];
            ovf_report_enable    <= wd[`OCS_BIT_OVF_EN];
            standby              <= wd[`OCS_BIT_STANDBY];
         end
      end
   end

   // -----------------------------------------
   // sample capture
   // -----------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_i <= {DW{1'b0}};
         cap_q <= {DW{1'b0}};
      end else if (capture) begin
         cap_i <= sample_i;
         cap_q <= sample_q;
      end
   end

   // -----------------------------------------
   // pins
   // -----------------------------------------
   reg ovf_pulse;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovf_pulse   <= 1'b0;
         pulse_n_pin <= 1'b1;
      end else begin
         ovf_pulse   <= ovf_hit & ovf_pin_pulse_select;
         pulse_n_pin <= ~wr_pulse;
      end
   end

   assign int_n_pin         = int_en ? arm : 1'b1;
   // disabling reporting also releases the pin while the flag is still set
   assign ovf_n_pin         = ovf_pin_pulse_select ? ~(ovf_pulse & ovf_report_enable)
                            : ~(ovf & ovf_report_enable);
   assign standby_request   = standby;
   assign output_data_valid = ~standby;

   // -----------------------------------------
   // signature
   // -----------------------------------------
   wire [7:0] sig_result;
   ocs_signature #(.DW(DW)) u_sig (
      .pclk       (pclk),
      .presetn    (presetn),
      .step       (sample_valid),
      .block_sync (block_sync_output),
      .frame_sync (frame_sync_output),
      .i_data     (sample_i),
      .q_data     (sample_q),
      .sync_fall  (sync_fall),
      .result     (sig_result)
   );

   // -----------------------------------------
   // read data
   // -----------------------------------------
   wire [7:0] stat_rd = {standby, ovf, ovf_report_enable, ovf_pin_pulse_select,
                         spare, int_en, lost, arm};
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel & ~penable & ~pwrite) begin
         case (paddr)
            `OCS_ADDR_STATUS:    prdata <= {24'h000000, stat_rd};
            `OCS_ADDR_SIGNATURE: prdata <= {24'h000000, sig_result};
            `OCS_ADDR_SAMPLE:    prdata <= {cap_q[15:0], cap_i[15:0]};
            default:             prdata <= 32'h00000000;
         endcase
      end
   end
endmodule
`default_nettype wire

//--- sim/ocs_status_unit_chk.sv
// port checker of the output capture status unit
`timescale 1ns/1ps
`default_nettype none
`include "ocs_regs.vh"
module ocs_chk (
   input wire logic        pclk,              // clock
   input wire logic        presetn,           // reset, low
   input wire logic        psel,              // apb select
   input wire logic        penable,           // apb access
   input wire logic        pwrite,            // apb direction
   input wire logic [11:0] paddr,             // apb address
   input wire logic        pslverr,           // apb error
   input wire logic        sample_valid,      // new sample
   input wire logic        overflow_event,    // overflow
   input wire logic        int_n_pin,         // interrupt
   input wire logic        ovf_n_pin,         // overflow pin
   input wire logic        pulse_n_pin,       // one-shot pin
   input wire logic        standby_request,   // standby
   input wire logic        output_data_valid  // data usable
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire acc = psel & penable;
   wire wr_acc = acc & pwrite;
   wire os_hit = wr_acc & (paddr == `OCS_ADDR_PULSE);
   sequence os_wr; os_hit; endsequence
   sequence os_pulse; !pulse_n_pin ##1 pulse_n_pin; endsequence
   pulse_fire_a: assert property (os_wr |=> os_pulse)
      else $error("one-shot pulse missing");
   pulse_src_a: assert property ($fell(pulse_n_pin) |-> $past(os_hit))
      else $error("one-shot pulse without write");
   standby_out_a: assert property (output_data_valid == !standby_request)
      else $error("data valid not inverse of standby");
   int_fall_a: assert property ($fell(int_n_pin) |-> $past(sample_valid | wr_acc))
      else $error("interrupt fell without cause");
   int_rise_a: assert property ($rose(int_n_pin) |-> $past(wr_acc))
      else $error("interrupt rose without write");
   ovf_fall_a: assert property ($fell(ovf_n_pin) |-> $past(overflow_event | wr_acc))
      else $error("overflow pin fell without cause");
   wo_read_a: assert property (acc & !pwrite & (paddr == `OCS_ADDR_PULSE) |-> pslverr)
      else $error("read of write-only place accepted");
   ro_write_a: assert property (wr_acc & (paddr == `OCS_ADDR_SIGNATURE) |-> pslverr)
      else $error("write of read-only place accepted");
endmodule
bind ocs_status_unit ocs_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pslverr(pslverr),
   .sample_valid(sample_valid), .overflow_event(overflow_event), .int_n_pin(int_n_pin),
   .ovf_n_pin(ovf_n_pin), .pulse_n_pin(pulse_n_pin), .standby_request(standby_request),
   .output_data_valid(output_data_valid));
`default_nettype wire

//--- sim/ocs_host.sv
// apb host model standing in for the processor
`timescale 1ns/1ps
`default_nettype none
module ocs_host (
   input wire logic        pclk,    // clock
   input wire logic        pready,  // apb ready
   input wire logic [31:0] prdata,  // apb read data
   input wire logic        pslverr, // apb error
   output logic            psel,    // apb select
   output logic            penable, // apb access
   output logic            pwrite,  // apb direction
   output logic [11:0]     paddr,   // apb address
   output logic [31:0]     pwdata,  // apb write data
   output logic [3:0]      pstrb    // apb strobes
);
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      pstrb = 4'hf;
   end
   task xfer(input w, input [11:0] a, input [31:0] d, output [31:0] q, output e);
      begin
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1) @(posedge pclk);
         q = prdata;
         e = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         pwdata <= ~d; // released data goes stale
      end
   endtask
endmodule
`default_nettype wire

//--- sim/testbench.sv
// self-checking bench of the output capture status unit
`timescale 1ns/1ps
`default_nettype none
`include "ocs_regs.vh"
module testbench;
   localparam [11:0] ST = `OCS_ADDR_STATUS, PU = `OCS_ADDR_PULSE;
   localparam [11:0] SG = `OCS_ADDR_SIGNATURE, SM = `OCS_ADDR_SAMPLE;
   logic pclk, presetn, sample_valid, overflow_event, internal_sync;
   logic block_sync_output, frame_sync_output;
   logic [15:0] sample_i, sample_q;
   wire psel, penable, pwrite, pready, pslverr, int_n_pin, ovf_n_pin, pulse_n_pin;
   wire standby_request, output_data_valid;
   wire [11:0] paddr;
   wire [31:0] pwdata, prdata;
   wire [3:0] pstrb;
   int errors, num_checks, cyc, nov, npl;
   logic [31:0] q;
   logic e;
   ocs_status_unit #(.DW(16)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .sample_valid(sample_valid),
      .sample_i(sample_i), .sample_q(sample_q), .block_sync_output(block_sync_output),
      .frame_sync_output(frame_sync_output), .overflow_event(overflow_event),
      .internal_sync(internal_sync), .int_n_pin(int_n_pin), .ovf_n_pin(ovf_n_pin),
      .pulse_n_pin(pulse_n_pin), .standby_request(standby_request),
      .output_data_valid(output_data_valid));
   ocs_host hst (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb));
   task chk(input [31:0] g, input [31:0] x);
      num_checks++;
      if (g !== x) begin
         errors++;
         $display("ERROR %0t got %h expected %h", $time, g, x);
      end
   endtask
   task wr(input [11:0] a, input [31:0] d);
      hst.xfer(1'b1, a, d, q, e);
      #1; // let registers and pins settle past the write edge
   endtask
   task rdc(input [11:0] a, input [31:0] x);
      hst.xfer(1'b0, a, 32'h0, q, e);
      chk(q, x);
      chk(e, 0);
   endtask
   task err(input w, input [11:0] a);
      hst.xfer(w, a, 32'h0, q, e);
      chk(e, 1);
   endtask
   task tick(input [3:0] k);
      @(posedge pclk);
      {frame_sync_output, block_sync_output, overflow_event, sample_valid} <= k;
      @(posedge pclk);
      {overflow_event, sample_valid} <= 2'b00;
   endtask
   // low cycles of the two pulse pins over four cycles
   task cnt;
      nov = 0;
      npl = 0;
      repeat (4) begin
         #1 nov += !ovf_n_pin;
         npl += !pulse_n_pin;
         @(posedge pclk);
      end
   endtask
   task tend(input string s);
      $display("test %s done", s);
   endtask
   task close_out;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      pclk = 0;
      forever #5 pclk = ~pclk;
   end
   initial begin
      cyc = 0;
      forever @(posedge pclk) if (++cyc == 3000) begin
         errors++;
         close_out;
      end
   end
   initial begin
      {presetn, sample_valid, overflow_event, block_sync_output, frame_sync_output} = '0;
      {sample_i, sample_q, errors, num_checks} = '0;
      internal_sync = 1;
      repeat (6) @(posedge pclk);
      presetn <= 1;
      rdc(ST, 0);
      rdc(SG, 0);
      chk({int_n_pin, ovf_n_pin, pulse_n_pin, standby_request, pready}, 5'h1d);
      tend("reset");
      wr(ST, 0);
      wr(ST, 1);
      wr(ST, 5);
      chk(int_n_pin, 1);
      sample_i <= 16'h1234;
      sample_q <= 16'habcd;
      tick(4'h1);
      #1 chk(int_n_pin, 0);
      rdc(ST, 4);
      wr(ST, 0);
      chk(int_n_pin, 1);
      rdc(SM, 32'habcd1234);
      tend("capture");
      tick(4'h5);
      rdc(ST, 2);
      wr(ST, 3);
      rdc(ST, 3);
      wr(ST, 1);
      rdc(ST, 1);
      sample_i <= 16'h5555;
      fork
         wr(ST, 1);
         begin
            repeat (2) @(posedge pclk);
            sample_valid <= 1;
            @(posedge pclk);
            sample_valid <= 0;
         end
      join
      rdc(ST, 1);
      tick(4'h1);
      rdc(ST, 3);
      rdc(SM, 32'habcd1234);
      tend("lost");
      wr(ST, 32'h20);
      tick(4'h2);
      cnt;
      chk(nov, 4);
      chk(ovf_n_pin, 0);
      rdc(ST, 32'h60);
      wr(ST, 32'h60);
      rdc(ST, 32'h60);
      wr(ST, 32'h20);
      rdc(ST, 32'h20);
      chk(ovf_n_pin, 1);
      wr(ST, 32'h30);
      tick(4'h2);
      cnt;
      chk(nov, 1);
      rdc(ST, 32'h70);
      wr(ST, 0);
      tick(4'h2);
      cnt;
      chk(nov, 0);
      rdc(ST, 0);
      tend("overflow");
      wr(ST, 32'h88);
      chk({standby_request, output_data_valid}, 2'b10);
      rdc(ST, 32'h88);
      wr(ST, 0);
      tend("standby");
      wr(PU, 32'hffffffff);
      cnt;
      chk(npl, 1);
      wr(PU, 0);
      cnt;
      chk(npl, 1);
      err(0, PU);
      err(1, SG);
      err(0, 12'h040);
      tend("oneshot");
      tick(4'hd);
      internal_sync <= 0;
      repeat (5) @(posedge pclk);
      hst.xfer(1'b0, SG, 32'h0, q, e);
      chk(q != 32'h0, 1);
      internal_sync <= 1;
      repeat (5) @(posedge pclk);
      internal_sync <= 0;
      repeat (5) @(posedge pclk);
      rdc(SG, 0);
      tend("signature");
      close_out;
   end
endmodule
`default_nettype wire
